/* File: design/tcu_pkg.sv */
/*
 capture unit package: register map, mode codes, field layout.
 assumes a 32-bit classic wishbone slave with word-aligned registers.
*/
package tcu_pkg;
    localparam int unsigned addr_w = 4;
    localparam logic [3:0] adr_ctrl = 4'h0;
    localparam logic [3:0] adr_value = 4'h4;
    localparam logic [3:0] adr_flags = 4'h8;
    localparam logic [3:0] adr_enables = 4'hc;
    localparam logic [3:0] adr_pin = 4'h0;
    // mode field codes, fixed package localparams
    localparam logic [3:0] mode_off = 4'h0;
    localparam logic [3:0] mode_fall = 4'h4;
    localparam logic [3:0] mode_rise = 4'h5;
    localparam logic [3:0] mode_rise4 = 4'h6;
    localparam logic [3:0] mode_rise16 = 4'h7;
    localparam int unsigned irq_bit = 2;
    localparam int unsigned dir_bit = 8;
    localparam logic [3:0] pre_div4 = 4'h3;
    localparam logic [3:0] pre_div16 = 4'hf;
    localparam logic [3:0] pre_zero = 4'h0;
    localparam logic [7:0] flags_rst = 8'h00;
    localparam logic [15:0] value_rst = 16'h0000;
endpackage

/* File: design/tcu_capture.sv */
/*
 timer capture unit: latches a 16-bit timer count on a selected pin event.
 assumes timer_count comes from logic on the same clock; the pin is async.
*/
// Decided for this implementation: the register offsets and the Wishbone register port.
// What this block does
// - a qualifying event copies the whole 16-bit timer count into the pair.
// - a 4-bit mode picks falling, rising, every 4th or every 16th rising.
// - each capture sets the capture flag at bit 2 of the flag register.
// - only software clears the flag, by writing a one to it.
// - a new capture simply overwrites the earlier stored value.
// - the pin is watched whatever its direction bit says.
// - a mode change may raise the flag; software masks and clears it.
// - the prescaler counter is held at zero outside the capture modes.
// - any reset clears the prescaler counter.
// - moving straight between capture modes keeps the prescaler count.
`timescale 1ns/1ns
module tcu_capture
    import tcu_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [tcu_pkg::addr_w-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // timer and pin
    input wire logic [15:0] timer_count_pair,
    input wire logic capture_input_pin,
    output logic port_c_direction,
    // interrupt
    output logic irq
);
    import tcu_pkg::*;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic last;
        logic [3:0] mode;
        logic [3:0] prescale;
        logic [15:0] value;
        logic [7:0] flags;
        logic [7:0] enables;
        logic dir;
        logic ack;
        logic [31:0] rdata;
        logic irq;
    } tcu_state_s;

    tcu_state_s st, nx;

    function automatic logic is_capture(input logic [3:0] m);
        return m == mode_fall || m == mode_rise || m == mode_rise4 ||
            m == mode_rise16;
    endfunction

    logic rise, fall, event_hit, wr, rd_req, captured;
    logic [7:0] next_flags;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        nx = st;
        nx.sync1 = capture_input_pin;
        nx.sync2 = st.sync1;
        nx.last = st.sync2;
        rise = st.sync2 && !st.last;
        fall = !st.sync2 && st.last;
        event_hit = 1'b0;
        unique case (st.mode)
            mode_fall: event_hit = fall;
            mode_rise: event_hit = rise;
            mode_rise4: event_hit = rise && st.prescale[1:0] == pre_div4[1:0];
            mode_rise16: event_hit = rise && st.prescale == pre_div16;
            default: event_hit = 1'b0;
        endcase
        // prescaler runs across capture modes without clearing
        if (!is_capture(st.mode)) begin
            nx.prescale = pre_zero;
        end else if (rise) begin
            nx.prescale = st.prescale + 4'h1;
        end
        captured = event_hit;
        if (captured) begin
            nx.value = timer_count_pair;
        end
        wr = wb_cyc_i && wb_stb_i && wb_we_i && !st.ack;
        rd_req = wb_cyc_i && wb_stb_i && !st.ack;
        next_flags = st.flags;
        if (wr && wb_adr_i == adr_flags && wb_sel_i[0]) begin
            next_flags = st.flags & ~wb_dat_i[7:0];
        end
        if (captured) begin
            next_flags[irq_bit] = 1'b1;
        end
        nx.flags = next_flags;
        if (wr && wb_adr_i == adr_ctrl && wb_sel_i[0]) begin
            nx.mode = wb_dat_i[3:0];
        end
        if (wr && wb_adr_i == adr_ctrl && wb_sel_i[1]) begin
            nx.dir = wb_dat_i[dir_bit];
        end
        if (wr && wb_adr_i == adr_enables && wb_sel_i[0]) begin
            nx.enables = wb_dat_i[7:0];
        end
        nx.ack = rd_req;
        nx.rdata = 32'h0000_0000;
        if (rd_req && !wb_we_i) begin
            unique case (wb_adr_i)
                adr_ctrl: nx.rdata = {23'h0, st.dir, 4'h0, st.mode};
                adr_value: nx.rdata = {16'h0, st.value};
                adr_flags: nx.rdata = {24'h0, st.flags};
                adr_enables: nx.rdata = {24'h0, st.enables};
                default: nx.rdata = 32'h0000_0000;
            endcase
        end
        nx.irq = |(next_flags & nx.enables);
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.dir <= 1'b1;
            st.value <= value_rst;
            st.flags <= flags_rst;
        end else begin
            st <= nx;
        end
    end

    assign wb_dat_o = st.rdata;
    assign wb_ack_o = st.ack;
    assign port_c_direction = st.dir;
    assign irq = st.irq;

    ////////////////////////////////////////////////////////////////////
    sequence rise_seen;
        st.mode == mode_rise && st.sync2 && !st.last;
    endsequence

    capture_load_a: assert property (@(posedge clock) disable iff (rst)
        rise_seen |=> st.value == $past(timer_count_pair))
        else $error("rising capture did not load timer");
    flag_set_a: assert property (@(posedge clock) disable iff (rst)
        rise_seen |=> st.flags[irq_bit])
        else $error("capture did not set flag");
    flag_hold_a: assert property (@(posedge clock) disable iff (rst)
        st.flags[irq_bit] && !(wr && wb_adr_i == adr_flags && wb_sel_i[0]
        && wb_dat_i[irq_bit]) |=> st.flags[irq_bit])
        else $error("flag cleared without software");
    prescale_off_a: assert property (@(posedge clock) disable iff (rst)
        !is_capture(st.mode) |=> st.prescale == pre_zero)
        else $error("prescaler not held at zero");
    fall_mode_a: assert property (@(posedge clock) disable iff (rst)
        st.mode == mode_fall && st.sync2 && !st.last |=>
        $stable(st.value))
        else $error("rising edge captured in falling mode");
    div16_a: assert property (@(posedge clock) disable iff (rst)
        st.mode == mode_rise16 && st.prescale != pre_div16 |=>
        !$changed(st.value) || $past(st.mode) != mode_rise16)
        else $error("divide by sixteen captured early");
    keep_count_a: assert property (@(posedge clock) disable iff (rst)
        is_capture(st.mode) && !(st.sync2 && !st.last) |=>
        st.prescale == $past(st.prescale))
        else $error("prescaler changed without an edge");
    ack_once_a: assert property (@(posedge clock) disable iff (rst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    ////////////////////////////////////////////////////////////////////
    sequence fall_seen;
        st.mode == mode_fall && !st.sync2 && st.last;
    endsequence

    sequence rise4_seen;
        st.mode == mode_rise4 && st.sync2 && !st.last &&
        st.prescale[1:0] == pre_div4[1:0];
    endsequence

    sequence rise16_seen;
        st.mode == mode_rise16 && st.sync2 && !st.last &&
        st.prescale == pre_div16;
    endsequence

    sequence clear_req;
        wr && wb_adr_i == adr_flags && wb_sel_i[0] && wb_dat_i[irq_bit];
    endsequence

    sequence read_req;
        rd_req && !wb_we_i;
    endsequence

    fall_load_a: assert property (@(posedge clock) disable iff (rst)
        fall_seen |=> st.value == $past(timer_count_pair))
        else $error("falling capture did not load timer");

    rise4_load_a: assert property (@(posedge clock) disable iff (rst)
        rise4_seen |=> st.value == $past(timer_count_pair))
        else $error("fourth rise did not load timer");

    rise16_load_a: assert property (@(posedge clock) disable iff (rst)
        rise16_seen |=> st.value == $past(timer_count_pair))
        else $error("sixteenth rise did not load timer");

    fall_flag_a: assert property (@(posedge clock) disable iff (rst)
        fall_seen |=> st.flags[irq_bit])
        else $error("falling capture did not set flag");

    rise4_flag_a: assert property (@(posedge clock) disable iff (rst)
        rise4_seen |=> st.flags[irq_bit])
        else $error("fourth rise did not set flag");

    rise16_flag_a: assert property (@(posedge clock) disable iff (rst)
        rise16_seen |=> st.flags[irq_bit])
        else $error("sixteenth rise did not set flag");

    div4_early_a: assert property (@(posedge clock) disable iff (rst)
        st.mode == mode_rise4 && st.prescale[1:0] != pre_div4[1:0] |=>
        $stable(st.value))
        else $error("divide by four captured early");

    off_hold_a: assert property (@(posedge clock) disable iff (rst)
        !is_capture(st.mode) |=> $stable(st.value))
        else $error("capture while unit off");

    overwrite_a: assert property (@(posedge clock) disable iff (rst)
        rise_seen ##0 st.flags[irq_bit] |=>
        st.value == $past(timer_count_pair))
        else $error("pending value not overwritten");

    flag_clear_a: assert property (@(posedge clock) disable iff (rst)
        clear_req ##0 !event_hit |=> !st.flags[irq_bit])
        else $error("flag not cleared by software");

    set_wins_a: assert property (@(posedge clock) disable iff (rst)
        clear_req ##0 event_hit |=> st.flags[irq_bit])
        else $error("clear beat a capture");

    irq_level_a: assert property (@(posedge clock) disable iff (rst)
        irq == |(st.flags & st.enables))
        else $error("irq level wrong");

    sync_chain_a: assert property (@(posedge clock) disable iff (rst)
        1'b1 |=> st.sync2 == $past(st.sync1) && st.last == $past(st.sync2))
        else $error("pin synchroniser chain broken");

    prescale_step_a: assert property (@(posedge clock) disable iff (rst)
        is_capture(st.mode) && st.sync2 && !st.last |=>
        st.prescale == $past(st.prescale) + 4'h1)
        else $error("prescaler missed a rise");

    switch_keep_a: assert property (@(posedge clock) disable iff (rst)
        is_capture(st.mode) && !(st.sync2 && !st.last) && wr &&
        wb_adr_i == adr_ctrl && wb_sel_i[0] |=> $stable(st.prescale))
        else $error("mode write cleared prescaler");

    mode_write_a: assert property (@(posedge clock) disable iff (rst)
        wr && wb_adr_i == adr_ctrl && wb_sel_i[0] |=>
        st.mode == $past(wb_dat_i[3:0]))
        else $error("mode write lost");

    mode_hold_a: assert property (@(posedge clock) disable iff (rst)
        !(wr && wb_adr_i == adr_ctrl && wb_sel_i[0]) |=> $stable(st.mode))
        else $error("mode changed without write");

    dir_write_a: assert property (@(posedge clock) disable iff (rst)
        wr && wb_adr_i == adr_ctrl && wb_sel_i[1] |=>
        port_c_direction == $past(wb_dat_i[dir_bit]))
        else $error("direction write lost");

    pin_any_dir_a: assert property (@(posedge clock) disable iff (rst)
        st.dir == 1'b0 ##0 rise_seen |=>
        st.value == $past(timer_count_pair))
        else $error("output pin edge not captured");

    value_ro_a: assert property (@(posedge clock) disable iff (rst)
        wr && wb_adr_i == adr_value && !event_hit |=> $stable(st.value))
        else $error("value register written");

    value_read_a: assert property (@(posedge clock) disable iff (rst)
        read_req ##0 wb_adr_i == adr_value |=>
        wb_ack_o && wb_dat_o == {16'h0, $past(st.value)})
        else $error("value read wrong");

    flag_read_a: assert property (@(posedge clock) disable iff (rst)
        read_req ##0 wb_adr_i == adr_flags |=>
        wb_dat_o == {24'h0, $past(st.flags)})
        else $error("flag read wrong");

    enables_write_a: assert property (@(posedge clock) disable iff (rst)
        wr && wb_adr_i == adr_enables && wb_sel_i[0] |=>
        st.enables == $past(wb_dat_i[7:0]))
        else $error("enable write lost");

    ack_answer_a: assert property (@(posedge clock) disable iff (rst)
        rd_req |=> wb_ack_o)
        else $error("request not acknowledged");

    ack_idle_a: assert property (@(posedge clock) disable iff (rst)
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");

    data_idle_a: assert property (@(posedge clock) disable iff (rst)
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");
endmodule // tcu_capture

/* File: tb/tcu_pin_src.sv */
/*
 event source model that drives the capture pin.
 assumes the bench calls its tasks right after a rising clock edge.
*/
`timescale 1ns/1ns
module tcu_pin_src (
    // clock and pin
    input wire logic clock,
    output logic pin
);
    initial pin = 1'b0;
    // each level is held six clocks so the synchroniser sees it
    task automatic put(input logic v);
        pin <= v;
        repeat (6) @(posedge clock);
    endtask
    task automatic rises(input int n);
        repeat (n) begin
            put(1'b1);
            put(1'b0);
        end
    endtask
endmodule // tcu_pin_src

/* File: tb/testbench.sv */
/*
 self-checking bench for the capture unit over wishbone.
 assumes the pin model and a bench-driven timer on the same clock.
*/
`timescale 1ns/1ns
module testbench;
    import tcu_pkg::*;
    logic clock, rst, cyc, stb, we, ack, pin, dir, irq;
    logic [3:0] adr, sel;
    logic [31:0] wdat, rdat, got;
    logic [15:0] tmr;
    int failures, compares, cycles;
    tcu_capture dut (.clock(clock), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .timer_count_pair(tmr), .capture_input_pin(pin),
        .port_c_direction(dir), .irq(irq));
    tcu_pin_src src (.clock(clock), .pin(pin));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic report_and_stop;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            report_and_stop;
        end
    end
    task automatic check(input string n, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hf;
        adr <= a;
        wdat <= d;
        @(posedge clock);
        while (ack !== 1'b1) @(posedge clock);
        got = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check($sformatf("reg %h", a), e, got);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, cyc, stb, we, adr, wdat, tmr} = {1'b1, 55'h0};
        {failures, compares, cycles} = '0;
        sel = 4'h0;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(adr_ctrl, 32'h100);
        rd(adr_value, 32'h0);
        check("dir", 1, dir);
        bus(1'b1, adr_enables, 32'h4);
        bus(1'b1, adr_ctrl, {28'h10, mode_rise});
        tmr <= 16'ha5c3;
        src.rises(1);
        check("irq", 1, irq);
        rd(adr_value, 32'ha5c3);
        rd(adr_flags, 32'h4);
        tmr <= 16'h5a3c;
        src.rises(1);
        bus(1'b1, adr_value, 32'h0);
        rd(adr_value, 32'h5a3c);
        rd(4'h6, 32'h0);
        bus(1'b1, adr_flags, 32'h4);
        rd(adr_flags, 32'h0);
        check("irq", 0, irq);
        bus(1'b1, adr_ctrl, {28'h0, mode_fall});
        bus(1'b1, adr_flags, 32'h4);
        check("dir", 0, dir);
        tmr <= 16'h1111;
        src.put(1'b1);
        rd(adr_flags, 32'h0);
        tmr <= 16'h2222;
        src.put(1'b0);
        rd(adr_value, 32'h2222);
        bus(1'b1, adr_ctrl, {28'h10, mode_off});
        bus(1'b1, adr_ctrl, {28'h10, mode_rise4});
        bus(1'b1, adr_flags, 32'h4);
        tmr <= 16'h3333;
        src.rises(3);
        rd(adr_flags, 32'h0);
        src.rises(1);
        rd(adr_value, 32'h3333);
        bus(1'b1, adr_ctrl, {28'h10, mode_off});
        bus(1'b1, adr_ctrl, {28'h10, mode_rise4});
        src.rises(2);
        bus(1'b1, adr_ctrl, {28'h10, mode_rise16});
        bus(1'b1, adr_flags, 32'h4);
        src.rises(13);
        rd(adr_flags, 32'h0);
        src.rises(1);
        rd(adr_flags, 32'h4);
        report_and_stop;
    end
endmodule // testbench
